/* File: bench/rseq_line_party.sv */
// Purpose: Outside party on the shared reset line
// Assumes: Device pulls the line low while oe_n is low
// Notes:   A released line reads high through the pull-up
`timescale 1ns/1ps
module rseq_line_party (
   input  wire logic clk,
   input  wire logic oe_n,
   output logic      pin
);
   logic pull_low = 1'b0;

   // Wired-AND of both drivers, pull-up otherwise
   assign pin = !(pull_low || oe_n === 1'b0);

   // Holds the line low for n whole cycles
   task automatic pull(input int n);
      @(posedge clk);
      pull_low <= 1'b1;
      repeat (n) @(posedge clk);
      pull_low <= 1'b0;
   endtask
endmodule

/* File: bench/rseq_top_properties.sv */
// Purpose: Port timing properties of the reset sequencer
// Assumes: One clock domain, synchronous active low reset
// Notes:   Counters measure pin drive width and stabilisation length
`timescale 1ns/1ps
module rseq_top_properties #(
   parameter int STAB_CYCLES    = 4096,
   parameter int PIN_OUT_CYCLES = 100
) (
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic        LOW_SUPPLY,
   input wire logic        WDG_UNDERFLOW,
   input wire logic        RST_PIN_I,
   input wire logic        RST_PIN_OE_N,
   input wire logic [1:0]  LVD_LEVEL,
   input wire logic [2:0]  CLK_SRC,
   input wire logic        CPU_RESET,
   input wire logic        VEC_FETCH,
   input wire logic [15:0] VEC_ADDR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   logic [15:0] low_cnt;
   logic [15:0] stab_cnt;
   logic [15:0] next_low;
   logic [15:0] next_stab;

   always_comb begin
      next_low  = RST_PIN_OE_N ? 16'h0 : low_cnt + 16'h1;
      next_stab = (RST_PIN_OE_N && CPU_RESET) ? stab_cnt + 16'h1 : 16'h0;
   end

   always_ff @(posedge CLK) begin
      low_cnt  <= RST_N ? next_low : 16'h0;
      stab_cnt <= RST_N ? next_stab : 16'h0;
   end

   sequence s_fetch;
      VEC_ADDR == 16'hFFFE ##1 VEC_FETCH && VEC_ADDR == 16'hFFFF
      ##1 !VEC_FETCH;
   endsequence
   property p_fetch;
      $rose(VEC_FETCH) |-> s_fetch;
   endproperty
   property p_low;
      LOW_SUPPLY |=> CPU_RESET && !RST_PIN_OE_N;
   endproperty
   property p_wdg;
      WDG_UNDERFLOW |=> !RST_PIN_OE_N [*4];
   endproperty
   property p_order;
      $rose(VEC_FETCH) |-> stab_cnt == STAB_CYCLES && $past(CPU_RESET);
   endproperty
   // Release edge of the reset is allowed one cycle of slack
   property p_width;
      $rose(RST_PIN_OE_N) |-> low_cnt >= PIN_OUT_CYCLES - 1;
   endproperty
   property p_idle;
      !CPU_RESET |-> RST_PIN_OE_N;
   endproperty
   property p_ext;
      !RST_PIN_I && RST_PIN_OE_N && !CPU_RESET |-> ##[1:4] CPU_RESET;
   endproperty
   property p_strap;
      $past(RST_N) |-> $stable(LVD_LEVEL) && $stable(CLK_SRC)
         && LVD_LEVEL != 2'h3 && CLK_SRC != 3'h7;
   endproperty

   a_fetch: assert property (p_fetch)
      else $error("Vector fetch shape wrong");
   a_low: assert property (p_low)
      else $error("Low supply did not hold reset");
   a_wdg: assert property (p_wdg)
      else $error("Watchdog pin drive too short");
   a_order: assert property (p_order)
      else $error("Stabilisation count wrong");
   a_width: assert property (p_width)
      else $error("Pin released too early");
   a_idle: assert property (p_idle)
      else $error("Pin driven while running");
   a_ext: assert property (p_ext)
      else $error("External pin low not taken");
   a_strap: assert property (p_strap)
      else $error("Option strap changed or illegal");
endmodule

bind rseq_top rseq_top_properties #(
   .STAB_CYCLES(STAB_CYCLES),
   .PIN_OUT_CYCLES(PIN_OUT_CYCLES)
) i_rseq_top_properties (
   .CLK(CLK), .RST_N(RST_N), .LOW_SUPPLY(LOW_SUPPLY),
   .WDG_UNDERFLOW(WDG_UNDERFLOW), .RST_PIN_I(RST_PIN_I),
   .RST_PIN_OE_N(RST_PIN_OE_N), .LVD_LEVEL(LVD_LEVEL), .CLK_SRC(CLK_SRC),
   .CPU_RESET(CPU_RESET), .VEC_FETCH(VEC_FETCH), .VEC_ADDR(VEC_ADDR)
);

/* File: bench/tb_rseq_top.sv */
// Purpose: Self-checking bench of the reset sequencer
// Assumes: Shortened pin width and stabilisation counts
// Notes:   Read data is checked from a queue of expected words
`timescale 1ns/1ps
module tb_rseq_top;
   localparam int P = 4;
   localparam int S = 16;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        low_supply = 1'b0;
   logic        wdg = 1'b0;
   logic [1:0]  opt_lvl = 2'h0;
   logic [2:0]  opt_clk = 3'h0;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic        pin, pin_o, oe_n, cpu_reset, vec_fetch, irq, ack;
   logic [1:0]  lvl, lv, el;
   logic [2:0]  csrc, cv, ec;
   logic [15:0] vaddr;
   logic [31:0] rdat;
   logic [31:0] exp_q[$];
   int          mismatches = 0;
   int          compares = 0;
   int          seed = 32'h08862563;
   int          n, low;

   initial forever #5 clk = ~clk;

   rseq_top #(.STAB_CYCLES(S), .PIN_OUT_CYCLES(P)) i_rseq_top (
      .CLK(clk), .RST_N(rst_n), .LOW_SUPPLY(low_supply),
      .WDG_UNDERFLOW(wdg), .RST_PIN_I(pin), .RST_PIN_O(pin_o),
      .RST_PIN_OE_N(oe_n), .OPT_LVD_LEVEL(opt_lvl), .OPT_CLK_SRC(opt_clk),
      .LVD_LEVEL(lvl), .CLK_SRC(csrc), .CPU_RESET(cpu_reset),
      .VEC_FETCH(vec_fetch), .VEC_ADDR(vaddr), .IRQ(irq),
      .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_ACK_O(ack), .WB_DAT_O(rdat));
   rseq_line_party i_rseq_line_party (.clk(clk), .oe_n(oe_n), .pin(pin));

   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         check("read data", exp_q.pop_front(), rdat);
      end
   end

   // A read notes its expected word before the request goes out
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      if (!w) exp_q.push_back(d);
      @(posedge clk);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= w ? d : 32'h0;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic run_seq(output int cn, output int ln);
      cn = 0;
      ln = 0;
      do begin
         @(posedge clk);
         #1;
         cn++;
         if (oe_n === 1'b0) ln++;
      end while (vec_fetch !== 1'b1 && cn < 5000);
      // A sequence that never reaches the fetch counts as a failure
      check("sequence ends", 32'h1, {31'h0, vec_fetch === 1'b1});
      check("first vector", 32'hFFFE, {16'h0, vaddr});
      @(posedge clk);
      #1;
      check("second vector", 32'hFFFF, {16'h0, vaddr});
      @(posedge clk);
      #1;
      check("fetch end", 32'h0, {30'h0, vec_fetch, cpu_reset});
   endtask

   task automatic pulse_wdg();
      @(posedge clk);
      wdg <= 1'b1;
      @(posedge clk);
      wdg <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      #500000;
      mismatches++;
      report_and_stop();
   end

   initial begin
      for (int k = 0; k < 8; k++) begin
         lv = 2'($random(seed));
         cv = k[2:0];
         el = (lv == 2'h3) ? 2'h0 : lv;
         ec = (cv == 3'h7) ? 3'h0 : cv;
         @(posedge clk);
         rst_n   <= 1'b0;
         opt_lvl <= lv;
         opt_clk <= cv;
         repeat (16) @(posedge clk);
         rst_n <= 1'b1;
         run_seq(n, low);
         check("level", {30'h0, el}, {30'h0, lvl});
         check("clock", {29'h0, ec}, {29'h0, csrc});
         bus(1'b0, 4'hC, {25'h0, ec, 2'h0, el});
      end
      $display("strap test done");
      bus(1'b0, 4'h0, 32'h10);
      bus(1'b1, 4'h0, 32'hFF);
      bus(1'b0, 4'h0, 32'h10);
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b0, 4'h0, 32'h0);
      $display("flag test done");
      bus(1'b1, 4'h8, 32'h4);
      pulse_wdg();
      // Counting starts one cycle after the pin went low
      run_seq(n, low);
      check("wdg seq length", P + S, n);
      check("wdg pin width", P - 1, low);
      bus(1'b0, 4'h0, 32'h1);
      check("irq raised", 32'h1, {31'h0, irq});
      bus(1'b1, 4'h4, 32'hF);
      #1;
      check("irq cleared", 32'h0, {31'h0, irq});
      $display("watchdog test done");
      bus(1'b1, 4'h8, 32'h0);
      fork
         i_rseq_line_party.pull(3 + int'($unsigned($random(seed)) % 3));
         run_seq(n, low);
      join
      check("ext pin width", 32'h1, {31'h0, low >= P});
      bus(1'b0, 4'h0, 32'h1);
      bus(1'b0, 4'h4, 32'h9);
      check("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, 4'h8, 32'h1);
      #1;
      check("irq unmasked", 32'h1, {31'h0, irq});
      fork
         i_rseq_line_party.pull(80);
         run_seq(n, low);
      join
      check("long pulse", 32'h1, {31'h0, n > 80});
      $display("external test done");
      @(posedge clk);
      low_supply <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      check("supply hold", 32'h2, {30'h0, cpu_reset, oe_n});
      check("pin drive value", 32'h0, {31'h0, pin_o});
      @(posedge clk);
      low_supply <= 1'b0;
      run_seq(n, low);
      bus(1'b0, 4'h0, 32'h10);
      pulse_wdg();
      run_seq(n, low);
      bus(1'b0, 4'h0, 32'h11);
      $display("supply test done");
      report_and_stop();
   end
endmodule

/* File: design/rseq_ext_detect.sv */
// Purpose: Catches a low level on the reset pin without needing the clock
// Assumes: req_clear is synchronous to clk
// Notes:   The catch flop is set by the pin itself, so halt mode still sees it
`timescale 1ns/1ps
module rseq_ext_detect (
   input  wire logic  clk,
   input  wire logic  rst_n,
   rseq_pin_if.detect pin
);

   logic caught;
   logic next_caught;
   logic sync_a;
   logic sync_b;

   // A clear cannot beat a pin that is still low: the set is level sensitive
   always_comb begin
      next_caught = pin.req_clear ? 1'b0 : caught;
   end

   always_ff @(posedge clk or negedge pin.pin_level) begin
      if (!pin.pin_level) begin
         caught <= 1'b1;
      end else if (!rst_n) begin
         caught <= 1'b0;
      end else begin
         caught <= next_caught;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= caught;
         sync_b <= sync_a;
      end
   end

   assign pin.req_seen = sync_b;

endmodule

/* File: design/rseq_pin_if.sv */
// Purpose: Carries the external reset request between detector and sequencer
// Assumes: pin_level is the raw reset pin level, low active
// Notes:   req_seen is already in the CPU clock domain
`timescale 1ns/1ps
interface rseq_pin_if;
   logic pin_level;
   logic req_clear;
   logic req_seen;

   modport detect (
      input  pin_level,
      input  req_clear,
      output req_seen
   );

   modport seq (
      output pin_level,
      output req_clear,
      input  req_seen
   );
endinterface

/* File: design/rseq_pkg.sv */
// Purpose: Shared constants and types of the reset sequencer block
// Assumes: 100 MHz CPU clock, classic Wishbone register access
// Notes:   Offsets are byte addresses within a 16-byte window
package rseq_pkg;

   // Clock and timing
   localparam int CLK_MHZ          = 100;
   localparam int T_PIN_OUT_MIN_NS = 1000;
   // Least time, so round up
   localparam int PIN_OUT_RAW      = (T_PIN_OUT_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int PIN_OUT_CYCLES   = (PIN_OUT_RAW < 1) ? 1 : PIN_OUT_RAW;
   localparam int STAB_CYCLES      = 4096;
   localparam int FETCH_CYCLES     = 2;
   localparam int SETTLE_CYCLES    = 4;
   localparam int SYNC_LAT         = 2;
   localparam int CNT_W            = 13;

   // Reset vector location
   localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
   localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;

   // Register offsets
   localparam logic [3:0] REG_FLAGS   = 4'h0;
   localparam logic [3:0] REG_EVENTS  = 4'h4;
   localparam logic [3:0] REG_MASK    = 4'h8;
   localparam logic [3:0] REG_OPTIONS = 4'hC;

   // Field positions
   localparam int FLAG_WDG_BIT = 0;
   localparam int FLAG_LOW_BIT = 4;
   localparam int EV_EXT       = 0;
   localparam int EV_LOW       = 1;
   localparam int EV_WDG       = 2;
   localparam int EV_DONE      = 3;
   localparam int EV_W         = 4;
   localparam int OPT_LVL_LSB  = 0;
   localparam int OPT_CLK_LSB  = 4;

   // Reset values
   localparam logic [EV_W-1:0] EVENTS_RST = 4'h0;
   localparam logic [EV_W-1:0] MASK_RST   = 4'h0;

   typedef enum logic [1:0] {
      RSEQ_RUN   = 2'b00,
      RSEQ_HOLD  = 2'b01,
      RSEQ_STAB  = 2'b11,
      RSEQ_FETCH = 2'b10
   } rseq_state_t;

   typedef enum logic [1:0] {
      RSEQ_LVL_LOW  = 2'h0,
      RSEQ_LVL_MID  = 2'h1,
      RSEQ_LVL_HIGH = 2'h2
   } rseq_lvl_t;

   typedef enum logic [2:0] {
      RSEQ_CLK_EXT   = 3'h0,
      RSEQ_CLK_RES0  = 3'h1,
      RSEQ_CLK_RES1  = 3'h2,
      RSEQ_CLK_RES2  = 3'h3,
      RSEQ_CLK_RES3  = 3'h4,
      RSEQ_CLK_EXTRC = 3'h5,
      RSEQ_CLK_INTRC = 3'h6
   } rseq_clk_t;

endpackage

/* File: design/rseq_top.sv */
// Purpose: Reset sequencer: merges reset sources onto the shared reset pin
// Assumes: Supply and watchdog inputs are synchronous to CLK
// Notes:   Registers over classic Wishbone, one aligned word each
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
module rseq_top #(
   parameter int STAB_CYCLES    = rseq_pkg::STAB_CYCLES,
   parameter int PIN_OUT_CYCLES = rseq_pkg::PIN_OUT_CYCLES
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        LOW_SUPPLY,
   input  wire logic        WDG_UNDERFLOW,
   input  wire logic        RST_PIN_I,
   output logic             RST_PIN_O,
   output logic             RST_PIN_OE_N,
   input  wire logic [1:0]  OPT_LVD_LEVEL,
   input  wire logic [2:0]  OPT_CLK_SRC,
   output logic [1:0]       LVD_LEVEL,
   output logic [2:0]       CLK_SRC,
   output logic             CPU_RESET,
   output logic             VEC_FETCH,
   output logic [15:0]      VEC_ADDR,
   output logic             IRQ,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [3:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic             WB_ACK_O,
   output logic [31:0]      WB_DAT_O
);

   localparam int CW = rseq_pkg::CNT_W;

   // The release check window must fit inside the count
   if (STAB_CYCLES <= rseq_pkg::SETTLE_CYCLES + rseq_pkg::SYNC_LAT ||
       STAB_CYCLES >= (1 << CW) + 1 || PIN_OUT_CYCLES < 1 ||
       PIN_OUT_CYCLES >= (1 << CW)) begin : g_bad_param
      $error("rseq_top: count parameter out of range");
   end

   localparam logic [CW-1:0] STAB_LAST  = CW'(STAB_CYCLES - 1);
   localparam logic [CW-1:0] PIN_LAST   = CW'(PIN_OUT_CYCLES - 1);
   localparam logic [CW-1:0] FETCH_LAST = CW'(rseq_pkg::FETCH_CYCLES - 1);
   localparam logic [CW-1:0] SETTLE     = CW'(rseq_pkg::SETTLE_CYCLES);
   localparam logic [CW-1:0] CHECK_AT   =
      CW'(rseq_pkg::SETTLE_CYCLES + rseq_pkg::SYNC_LAT);

   function automatic logic hit(input logic [3:0] adr,
                                input logic [3:0] off);
      hit = (adr[3:2] == off[3:2]);
   endfunction

   function automatic logic [1:0] lvl_decode(input logic [1:0] opt);
      // Code 3 is not a level; fall back to the lowest threshold
      lvl_decode = (opt == 2'h3) ? rseq_pkg::RSEQ_LVL_LOW : opt;
   endfunction

   function automatic logic [2:0] clk_decode(input logic [2:0] opt);
      clk_decode = (opt == 3'h7) ? rseq_pkg::RSEQ_CLK_EXT : opt;
   endfunction

   rseq_pin_if pin_bus ();

   assign pin_bus.pin_level = RST_PIN_I;

   rseq_ext_detect u_detect (
      .clk   (CLK),
      .rst_n (RST_N),
      .pin   (pin_bus.detect)
   );

   // Sequencer state
   rseq_pkg::rseq_state_t state;
   rseq_pkg::rseq_state_t next_state;
   logic [CW-1:0]         cnt;
   logic [CW-1:0]         next_cnt;
   logic                  next_oe_n;
   logic                  next_cpu_reset;
   logic                  next_vec_fetch;
   logic [15:0]           next_vec_addr;
   logic                  next_req_clear;
   logic                  req_clear;
   logic                  ev_ext;
   logic                  ev_done;
   logic                  low_q;
   logic                  ext;
   logic                  internal_src;

   assign ext            = pin_bus.req_seen;
   assign pin_bus.req_clear = req_clear;
   assign internal_src   = LOW_SUPPLY | WDG_UNDERFLOW;

   always_comb begin
      next_state     = state;
      next_cnt       = cnt;
      next_oe_n      = RST_PIN_OE_N;
      next_cpu_reset = CPU_RESET;
      next_vec_fetch = 1'b0;
      next_vec_addr  = VEC_ADDR;
      next_req_clear = 1'b0;
      ev_ext         = 1'b0;
      ev_done        = 1'b0;
      unique case (state)
         rseq_pkg::RSEQ_RUN: begin
            if (internal_src || ext) begin
               next_state     = rseq_pkg::RSEQ_HOLD;
               next_cnt       = '0;
               next_oe_n      = 1'b0;
               next_cpu_reset = 1'b1;
               ev_ext         = ext & ~internal_src;
            end
         end
         rseq_pkg::RSEQ_HOLD: begin
            next_oe_n      = 1'b0;
            next_cpu_reset = 1'b1;
            if (internal_src) begin
               // Width restarts while supply or watchdog still stands
               next_cnt = '0;
            end else if (cnt != PIN_LAST) begin
               next_cnt = cnt + CW'(1);
            end else begin
               next_state     = rseq_pkg::RSEQ_STAB;
               next_cnt       = '0;
               next_oe_n      = 1'b1;
               next_req_clear = 1'b1;
            end
         end
         rseq_pkg::RSEQ_STAB: begin
            next_req_clear = (cnt < SETTLE);
            // Own drive echoes through the catch flop; only look once
            // the pull-up had time and the clear has passed the sync
            if (internal_src || (ext && cnt >= CHECK_AT)) begin
               next_state = rseq_pkg::RSEQ_HOLD;
               next_cnt   = '0;
               next_oe_n  = 1'b0;
               ev_ext     = ext & ~internal_src;
            end else if (cnt == STAB_LAST) begin
               next_state     = rseq_pkg::RSEQ_FETCH;
               next_cnt       = '0;
               next_cpu_reset = 1'b0;
               next_vec_fetch = 1'b1;
               next_vec_addr  = rseq_pkg::VEC_LO_ADDR;
            end else begin
               next_cnt = cnt + CW'(1);
            end
         end
         rseq_pkg::RSEQ_FETCH: begin
            if (internal_src || ext) begin
               next_state     = rseq_pkg::RSEQ_HOLD;
               next_cnt       = '0;
               next_oe_n      = 1'b0;
               next_cpu_reset = 1'b1;
               ev_ext         = ext & ~internal_src;
            end else if (cnt == FETCH_LAST) begin
               next_state = rseq_pkg::RSEQ_RUN;
               next_cnt   = '0;
               ev_done    = 1'b1;
            end else begin
               next_cnt       = cnt + CW'(1);
               next_vec_fetch = 1'b1;
               next_vec_addr  = rseq_pkg::VEC_HI_ADDR;
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state        <= rseq_pkg::RSEQ_HOLD;
         cnt          <= '0;
         RST_PIN_OE_N <= 1'b0;
         RST_PIN_O    <= 1'b0;
         CPU_RESET    <= 1'b1;
         VEC_FETCH    <= 1'b0;
         VEC_ADDR     <= rseq_pkg::VEC_LO_ADDR;
         req_clear    <= 1'b0;
         low_q        <= 1'b0;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         RST_PIN_OE_N <= next_oe_n;
         RST_PIN_O    <= 1'b0;
         CPU_RESET    <= next_cpu_reset;
         VEC_FETCH    <= next_vec_fetch;
         VEC_ADDR     <= next_vec_addr;
         req_clear    <= next_req_clear;
         low_q        <= LOW_SUPPLY;
      end
   end

   // Option straps are caught on clocked reset, not writable at run time
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         LVD_LEVEL <= lvl_decode(OPT_LVD_LEVEL);
         CLK_SRC   <= clk_decode(OPT_CLK_SRC);
      end
   end

   // Register file
   logic                  flag_low;
   logic                  flag_wdg;
   logic [rseq_pkg::EV_W-1:0] events;
   logic [rseq_pkg::EV_W-1:0] mask;
   logic                  next_flag_low;
   logic                  next_flag_wdg;
   logic [rseq_pkg::EV_W-1:0] next_events;
   logic [rseq_pkg::EV_W-1:0] next_mask;
   logic [rseq_pkg::EV_W-1:0] ev_set;
   logic                  next_ack;
   logic [31:0]           next_dat;
   logic                  wr;

   always_comb begin
      wr     = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[0];
      ev_set = '0;
      ev_set[rseq_pkg::EV_EXT]  = ev_ext;
      ev_set[rseq_pkg::EV_LOW]  = LOW_SUPPLY & ~low_q;
      ev_set[rseq_pkg::EV_WDG]  = WDG_UNDERFLOW;
      ev_set[rseq_pkg::EV_DONE] = ev_done;

      next_flag_low = flag_low;
      next_flag_wdg = flag_wdg;
      next_mask     = mask;
      next_events   = events;
      if (wr && hit(WB_ADR_I, rseq_pkg::REG_FLAGS)) begin
         if (!WB_DAT_I[rseq_pkg::FLAG_LOW_BIT]) begin
            next_flag_low = 1'b0;
         end
         if (!WB_DAT_I[rseq_pkg::FLAG_WDG_BIT]) begin
            next_flag_wdg = 1'b0;
         end
      end
      if (LOW_SUPPLY) begin
         next_flag_wdg = 1'b0;
      end
      // Hardware sets win over clears; watchdog, external never clear this
      if (LOW_SUPPLY) begin
         next_flag_low = 1'b1;
      end
      if (WDG_UNDERFLOW) begin
         next_flag_wdg = 1'b1;
      end
      if (wr && hit(WB_ADR_I, rseq_pkg::REG_EVENTS)) begin
         next_events = events & ~WB_DAT_I[rseq_pkg::EV_W-1:0];
      end
      next_events = next_events | ev_set;
      if (wr && hit(WB_ADR_I, rseq_pkg::REG_MASK)) begin
         next_mask = WB_DAT_I[rseq_pkg::EV_W-1:0];
      end

      next_ack = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
      next_dat = '0;
      if (next_ack && !WB_WE_I) begin
         if (hit(WB_ADR_I, rseq_pkg::REG_FLAGS)) begin
            next_dat[rseq_pkg::FLAG_LOW_BIT] = flag_low;
            next_dat[rseq_pkg::FLAG_WDG_BIT] = flag_wdg;
         end else if (hit(WB_ADR_I, rseq_pkg::REG_EVENTS)) begin
            next_dat[rseq_pkg::EV_W-1:0] = events;
         end else if (hit(WB_ADR_I, rseq_pkg::REG_MASK)) begin
            next_dat[rseq_pkg::EV_W-1:0] = mask;
         end else begin
            next_dat[rseq_pkg::OPT_LVL_LSB +: 2] = LVD_LEVEL;
            next_dat[rseq_pkg::OPT_CLK_LSB +: 3] = CLK_SRC;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         // Block reset is the power-on case, recorded as low supply
         flag_low <= 1'b1;
         flag_wdg <= 1'b0;
         events   <= rseq_pkg::EVENTS_RST;
         mask     <= rseq_pkg::MASK_RST;
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
         IRQ      <= 1'b0;
      end else begin
         flag_low <= next_flag_low;
         flag_wdg <= next_flag_wdg;
         events   <= next_events;
         mask     <= next_mask;
         WB_ACK_O <= next_ack;
         WB_DAT_O <= next_dat;
         IRQ      <= |(next_events & next_mask);
      end
   end

endmodule
